//--- hw/servo_gain_set_switcher.sv
// Servo gain set switcher: manual and condition-driven gain set selection
//
// What this block does
// - Low config digit picks method: 0 manual by select input, 2 automatic.
// - Each set holds seven gains; switching replaces the five non-follow gains of the active set.
// - Follow gain and compensation switch only in manual mode.
// - Follow pair switches only with select present, no command, motor stopped.
// - Otherwise follow pair holds while the other gains still switch.
// - Manual: select 0 applies set 1, select 1 applies set 2.
// - Automatic switching runs only under position control.
// - Condition true: wait time up, then ramp to set 2 over ramp time up.
// - Condition false: wait time down, then ramp to set 1 over ramp time down.
// - Condition code picks done on/off, near on/off, idle reference, reference on.
// - Outside position control codes 0,2,4 hold set 1, codes 1,3,5 set 2.
// - After a condition change, gains wait the direction's waiting time first.
// - During a ramp each gain except the follow pair moves linearly, ending exactly at ramp end.
// - Automatic switching works with PI or IP speed loop structure.
// - Waiting and ramp times are 16-bit unsigned counts of 1 ms.
`timescale 1ns/100ps
`default_nettype none
module servo_gain_set_switcher #(
	parameter int TICK_CYCLES_P = gain_switch_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic                                   sys_clk_i,
	input  wire logic                                   rst_i,
	// Avalon-MM slave
	input  wire gain_switch_pkg::avl_req_t              avl_req_i,
	output logic      [gain_switch_pkg::DATA_W-1:0]     avl_readdata_o,
	output logic                                        avl_waitrequest_o,
	// Motion status and host select
	input  wire gain_switch_pkg::motion_status_t        motion_i,
	// Effective gains and state
	output gain_switch_pkg::gain_vec_t                  gains_o,
	output logic                                        active_set_o,
	output logic                                        ramp_busy_o
);
	import gain_switch_pkg::*;

	localparam int TICK_W = $clog2(TICK_CYCLES_P + 1);

	logic [GAIN_W-1:0] gain_switch_config_q;
	logic [GAIN_W-1:0] wait_time_up_q;
	logic [GAIN_W-1:0] wait_time_down_q;
	logic [GAIN_W-1:0] ramp_time_up_q;
	logic [GAIN_W-1:0] ramp_time_down_q;
	logic [GAIN_W-1:0] loop_structure_config_q;
	logic [GAIN_W-1:0] gain_a_q [NUM_LANES];
	logic [GAIN_W-1:0] gain_b_q [NUM_LANES];
	switch_state_t     state_q;
	switch_state_t     state_d;
	logic [TICK_W-1:0] tick_cnt_q;
	logic              tick_q;
	logic [15:0]       ms_cnt_q;
	logic [15:0]       frac_q;
	logic              div_start_q;
	logic [15:0]       div_quot;
	logic              div_done;
	logic              follow_sel_q;
	logic [16:0]       weight;
	logic [DATA_W-1:0] rdata_d;
	logic              bus_req;
	logic              wr_hit;
	logic [3:0]        method;
	logic [3:0]        cond_code;
	logic              manual_mode;
	logic              auto_run;
	logic              structure_ok;
	logic              cond_a;
	logic              in_ramp;
	logic              state_entry;

	function automatic logic [GAIN_W-1:0] merge16(input logic [GAIN_W-1:0] old,
		input logic [DATA_W-1:0] wd, input logic [3:0] be);
		merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction : merge16

	// Bus slave: one wait cycle, then the request completes
	assign bus_req = avl_req_i.read | avl_req_i.write;
	assign wr_hit  = avl_req_i.write & ~avl_waitrequest_o;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			avl_waitrequest_o <= 1'b1;
			avl_readdata_o    <= '0;
		end else if (avl_waitrequest_o && bus_req) begin
			avl_waitrequest_o <= 1'b0;
			avl_readdata_o    <= rdata_d;
		end else begin
			avl_waitrequest_o <= 1'b1;
		end
	end

	always_comb begin
		rdata_d = '0;
		unique case (avl_req_i.address)
			OFS_CONFIG:    rdata_d[GAIN_W-1:0] = gain_switch_config_q;
			OFS_WAIT_UP:   rdata_d[GAIN_W-1:0] = wait_time_up_q;
			OFS_WAIT_DOWN: rdata_d[GAIN_W-1:0] = wait_time_down_q;
			OFS_RAMP_UP:   rdata_d[GAIN_W-1:0] = ramp_time_up_q;
			OFS_RAMP_DOWN: rdata_d[GAIN_W-1:0] = ramp_time_down_q;
			OFS_LOOP_CFG:  rdata_d[GAIN_W-1:0] = loop_structure_config_q;
			OFS_STATUS: begin
				rdata_d[ST_BIT_ACTIVE]               = active_set_o;
				rdata_d[ST_BIT_RAMP]                 = ramp_busy_o;
				rdata_d[ST_BIT_FOLLOW]               = follow_sel_q;
				rdata_d[ST_STATE_LSB +: 3]           = state_q;
			end
			default: begin
				for (int i = 0; i < NUM_LANES; i++) begin
					if (avl_req_i.address == OFS_GAIN_A + ADDR_W'(4 * i)) begin
						rdata_d[GAIN_W-1:0] = gain_a_q[i];
					end
					if (avl_req_i.address == OFS_GAIN_B + ADDR_W'(4 * i)) begin
						rdata_d[GAIN_W-1:0] = gain_b_q[i];
					end
				end
			end
		endcase
	end

	// Config and timing registers, live on the next cycle
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			gain_switch_config_q    <= CFG_RESET;
			wait_time_up_q          <= TIME_RESET;
			wait_time_down_q        <= TIME_RESET;
			ramp_time_up_q          <= TIME_RESET;
			ramp_time_down_q        <= TIME_RESET;
			loop_structure_config_q <= CFG_RESET;
		end else if (wr_hit) begin
			unique case (avl_req_i.address)
				OFS_CONFIG:    gain_switch_config_q <= merge16(gain_switch_config_q,
					avl_req_i.writedata, avl_req_i.byteenable);
				OFS_WAIT_UP:   wait_time_up_q <= merge16(wait_time_up_q,
					avl_req_i.writedata, avl_req_i.byteenable);
				OFS_WAIT_DOWN: wait_time_down_q <= merge16(wait_time_down_q,
					avl_req_i.writedata, avl_req_i.byteenable);
				OFS_RAMP_UP:   ramp_time_up_q <= merge16(ramp_time_up_q,
					avl_req_i.writedata, avl_req_i.byteenable);
				OFS_RAMP_DOWN: ramp_time_down_q <= merge16(ramp_time_down_q,
					avl_req_i.writedata, avl_req_i.byteenable);
				OFS_LOOP_CFG:  loop_structure_config_q <= merge16(loop_structure_config_q,
					avl_req_i.writedata, avl_req_i.byteenable);
				default: ;
			endcase
		end
	end

	// Mode decode; reserved method code falls back to manual
	assign method       = gain_switch_config_q[CFG_METHOD_LSB +: 4];
	assign cond_code    = gain_switch_config_q[CFG_COND_LSB +: 4];
	assign manual_mode  = (method != METHOD_AUTO);
	assign structure_ok = (loop_structure_config_q[1:0] == STRUCT_PI) ||
		(loop_structure_config_q[1:0] == STRUCT_IP);
	assign auto_run     = !manual_mode && motion_i.position_control && structure_ok;

	always_comb begin
		unique case (cond_code)
			COND_DONE_ON:  cond_a = motion_i.positioning_done_flag;
			COND_DONE_OFF: cond_a = !motion_i.positioning_done_flag;
			COND_NEAR_ON:  cond_a = motion_i.near_flag;
			COND_NEAR_OFF: cond_a = !motion_i.near_flag;
			COND_IDLE_REF: cond_a = motion_i.filter_idle && !motion_i.ref_input;
			COND_REF_ON:   cond_a = motion_i.ref_input;
			default:       cond_a = motion_i.positioning_done_flag;
		endcase
	end

	// Millisecond enable from the system clock
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b0;
		end else if (tick_cnt_q == TICK_W'(TICK_CYCLES_P - 1)) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
			tick_q     <= 1'b0;
		end
	end

	always_comb begin
		state_d = state_q;
		if (manual_mode) begin
			state_d = motion_i.gain_select ? ST_SET2 : ST_SET1;
		end else if (!auto_run) begin
			state_d = cond_code[0] ? ST_SET2 : ST_SET1;
		end else begin
			unique case (state_q)
				ST_SET1:      if (cond_a) state_d = ST_WAIT_UP;
				ST_WAIT_UP: begin
					if (!cond_a) state_d = ST_SET1;
					else if (ms_cnt_q >= wait_time_up_q) state_d = ST_RAMP_UP;
				end
				ST_RAMP_UP:   if (ms_cnt_q >= ramp_time_up_q) state_d = ST_SET2;
				ST_SET2:      if (!cond_a) state_d = ST_WAIT_DOWN;
				ST_WAIT_DOWN: begin
					if (cond_a) state_d = ST_SET2;
					else if (ms_cnt_q >= wait_time_down_q) state_d = ST_RAMP_DOWN;
				end
				ST_RAMP_DOWN: if (ms_cnt_q >= ramp_time_down_q) state_d = ST_SET1;
			endcase
		end
	end

	assign state_entry = (state_d != state_q);
	assign in_ramp     = (state_q == ST_RAMP_UP) || (state_q == ST_RAMP_DOWN);

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state_q <= ST_SET1;
		end else begin
			state_q <= state_d;
		end
	end

	// Elapsed time restarts from zero on every state change
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ms_cnt_q <= 16'h0000;
		end else if (state_entry) begin
			ms_cnt_q <= 16'h0000;
		end else if (tick_q && ms_cnt_q != 16'hFFFF) begin
			ms_cnt_q <= ms_cnt_q + 16'h0001;
		end
	end

	// Fraction kept in a register so a restarted division never glitches gains
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			div_start_q <= 1'b0;
			frac_q      <= 16'h0000;
		end else begin
			div_start_q <= tick_q && in_ramp && !state_entry;
			if (state_entry) begin
				frac_q <= 16'h0000;
			end else if (div_done && in_ramp) begin
				frac_q <= div_quot;
			end
		end
	end

	ramp_fraction_div u_div (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.start_i   (div_start_q),
		.num_i     (ms_cnt_q),
		.den_i     ((state_q == ST_RAMP_UP) ? ramp_time_up_q : ramp_time_down_q),
		.quot_o    (div_quot),
		.done_o    (div_done)
	);

	always_comb begin
		weight = 17'h00000;
		unique case (state_q)
			ST_SET1, ST_WAIT_UP:   weight = 17'h00000;
			ST_SET2, ST_WAIT_DOWN: weight = FULL_WEIGHT;
			ST_RAMP_UP:            weight = {1'b0, frac_q};
			ST_RAMP_DOWN:          weight = FULL_WEIGHT - {1'b0, frac_q};
		endcase
	end

	// Follow pair moves only when the drive is idle and stopped
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			follow_sel_q <= 1'b0;
		end else if (manual_mode && !motion_i.cmd_busy && motion_i.motor_stopped) begin
			follow_sel_q <= motion_i.gain_select;
		end
	end

	// One lane per gain: storage and output, blended except on the follow pair
	for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
		logic signed [16:0] diff;
		logic signed [34:0] prod;
		assign diff = $signed({1'b0, gain_b_q[g]}) - $signed({1'b0, gain_a_q[g]});
		assign prod = 35'(diff * $signed({1'b0, weight}));

		always_ff @(posedge sys_clk_i) begin
			if (rst_i) begin
				gain_a_q[g] <= GAIN_RESET[g];
				gain_b_q[g] <= GAIN_RESET[g];
			end else if (wr_hit && avl_req_i.address == OFS_GAIN_A + ADDR_W'(4 * g)) begin
				gain_a_q[g] <= merge16(gain_a_q[g], avl_req_i.writedata,
					avl_req_i.byteenable);
			end else if (wr_hit && avl_req_i.address == OFS_GAIN_B + ADDR_W'(4 * g)) begin
				gain_b_q[g] <= merge16(gain_b_q[g], avl_req_i.writedata,
					avl_req_i.byteenable);
			end
		end

		always_ff @(posedge sys_clk_i) begin
			if (rst_i) begin
				gains_o[g] <= GAIN_RESET[g];
			end else if (g == LANE_FOLLOW_GAIN || g == LANE_FOLLOW_COMP) begin
				gains_o[g] <= follow_sel_q ? gain_b_q[g] : gain_a_q[g];
			end else begin
				gains_o[g] <= 16'(gain_a_q[g] + prod[31:16]);
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			active_set_o <= 1'b0;
			ramp_busy_o  <= 1'b0;
		end else begin
			active_set_o <= (state_d == ST_RAMP_UP) || (state_d == ST_SET2) ||
				(state_d == ST_WAIT_DOWN);
			ramp_busy_o  <= (state_d == ST_RAMP_UP) || (state_d == ST_RAMP_DOWN);
		end
	end

	// Checks
	sequence s_rise_zero_wait;
		auto_run && state_q == ST_SET1 && cond_a && wait_time_up_q == 16'h0000;
	endsequence
	sequence s_enter_wait_up;
		state_q == ST_WAIT_UP && cond_a && auto_run;
	endsequence

	chk_zero_wait: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		s_rise_zero_wait ##1 s_enter_wait_up |=> state_q == ST_RAMP_UP)
		else $error("zero wait did not start ramp at once");
	chk_manual_pick: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		manual_mode && $stable(gain_switch_config_q) |=> active_set_o == $past(motion_i.gain_select))
		else $error("manual select not applied");
	chk_fixed_outside: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!manual_mode && !motion_i.position_control |=>
		state_q == ($past(cond_code[0]) ? ST_SET2 : ST_SET1))
		else $error("set not fixed outside position control");
	chk_wait_holds: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		state_q == ST_WAIT_UP ##1 state_q == ST_WAIT_UP |=> $stable(gains_o))
		else $error("gains moved during wait");
	chk_follow_auto: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!$past(manual_mode) |-> $stable(follow_sel_q))
		else $error("follow pair switched in automatic mode");
	chk_follow_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$changed(follow_sel_q) |-> $past(!motion_i.cmd_busy && motion_i.motor_stopped))
		else $error("follow pair switched while busy or moving");
	chk_revert_cancel: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		state_q == ST_WAIT_DOWN && auto_run && cond_a |=> state_q == ST_SET2 && ms_cnt_q == 16'h0000)
		else $error("reverted wait not cancelled");
	chk_ramp_end: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		state_q == ST_RAMP_UP && auto_run && ms_cnt_q >= ramp_time_up_q |=> state_q == ST_SET2
		##1 gains_o[0] == gain_b_q[0])
		else $error("ramp up did not land on set 2");
	chk_structure_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!structure_ok |=> state_q == ST_SET1 || state_q == ST_SET2)
		else $error("automatic switching with unsupported loop structure");
	chk_bus_answer: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		avl_waitrequest_o && bus_req |=> !avl_waitrequest_o ##1 avl_waitrequest_o)
		else $error("bus answer not one cycle");

endmodule : servo_gain_set_switcher
`default_nettype wire

//--- inc/gain_switch_pkg.sv
// Constants, types and register map of the servo gain set switcher
package gain_switch_pkg;

	localparam int DATA_W    = 32;
	localparam int ADDR_W    = 8;
	localparam int GAIN_W    = 16;
	localparam int NUM_LANES = 7;
	localparam int LANE_FOLLOW_GAIN = 4;
	localparam int LANE_FOLLOW_COMP = 5;

	// Byte offsets on the register bus
	localparam logic [ADDR_W-1:0] OFS_CONFIG    = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_WAIT_UP   = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_WAIT_DOWN = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_RAMP_UP   = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_RAMP_DOWN = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_LOOP_CFG  = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_GAIN_A    = 8'h40;
	localparam logic [ADDR_W-1:0] OFS_GAIN_B    = 8'h60;

	// Config fields
	localparam int CFG_METHOD_LSB = 0;
	localparam int CFG_COND_LSB   = 4;
	localparam logic [3:0] METHOD_AUTO = 4'h2;
	localparam logic [3:0] COND_DONE_ON  = 4'h0;
	localparam logic [3:0] COND_DONE_OFF = 4'h1;
	localparam logic [3:0] COND_NEAR_ON  = 4'h2;
	localparam logic [3:0] COND_NEAR_OFF = 4'h3;
	localparam logic [3:0] COND_IDLE_REF = 4'h4;
	localparam logic [3:0] COND_REF_ON   = 4'h5;
	localparam logic [1:0] STRUCT_PI = 2'h0;
	localparam logic [1:0] STRUCT_IP = 2'h1;

	// Status fields
	localparam int ST_BIT_ACTIVE = 0;
	localparam int ST_BIT_RAMP   = 1;
	localparam int ST_BIT_FOLLOW = 2;
	localparam int ST_STATE_LSB  = 4;

	// Reset values
	localparam logic [GAIN_W-1:0] CFG_RESET  = 16'h0000;
	localparam logic [GAIN_W-1:0] TIME_RESET = 16'h0000;
	typedef logic [NUM_LANES-1:0][GAIN_W-1:0] gain_vec_t;
	localparam gain_vec_t GAIN_RESET = {16'h0064, 16'h03E8, 16'h01F4, 16'h0064,
		16'h0190, 16'h07D0, 16'h0190};
	localparam logic [16:0] FULL_WEIGHT = 17'h10000;

	// Timing
	localparam int TIME_UNIT_NS  = 1000000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int TICK_CYCLES   = TIME_UNIT_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_SET1      = 3'b000,
		ST_WAIT_UP   = 3'b001,
		ST_RAMP_UP   = 3'b011,
		ST_SET2      = 3'b010,
		ST_WAIT_DOWN = 3'b110,
		ST_RAMP_DOWN = 3'b111
	} switch_state_t;

	typedef struct packed {
		logic position_control;
		logic positioning_done_flag;
		logic near_flag;
		logic filter_idle;
		logic ref_input;
		logic cmd_busy;
		logic motor_stopped;
		logic gain_select;
	} motion_status_t;

	typedef struct packed {
		logic [ADDR_W-1:0] address;
		logic              read;
		logic              write;
		logic [DATA_W-1:0] writedata;
		logic [3:0]        byteenable;
	} avl_req_t;

endpackage : gain_switch_pkg

//--- hw/ramp_fraction_div.sv
// Serial divider giving the ramp fraction (num << 16) / den
`timescale 1ns/100ps
`default_nettype none
module ramp_fraction_div (
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	// Request
	input  wire logic        start_i,
	input  wire logic [15:0] num_i,
	input  wire logic [15:0] den_i,
	// Result
	output logic      [15:0] quot_o,
	output logic             done_o
);
	logic [16:0] rem_q;
	logic [15:0] quo_q;
	logic [4:0]  cnt_q;
	logic        busy_q;
	logic [16:0] shifted;

	// Needs num < den, so the remainder never reaches bit 16
	assign shifted = {rem_q[15:0], 1'b0};

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rem_q  <= 17'h00000;
			quo_q  <= 16'h0000;
			cnt_q  <= 5'h00;
			busy_q <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i) begin
				rem_q  <= {1'b0, num_i};
				quo_q  <= 16'h0000;
				cnt_q  <= 5'h10;
				busy_q <= 1'b1;
			end else if (busy_q) begin
				if (shifted >= {1'b0, den_i}) begin
					rem_q <= shifted - {1'b0, den_i};
					quo_q <= {quo_q[14:0], 1'b1};
				end else begin
					rem_q <= shifted;
					quo_q <= {quo_q[14:0], 1'b0};
				end
				cnt_q <= cnt_q - 5'h01;
				if (cnt_q == 5'h01) begin
					busy_q <= 1'b0;
					done_o <= 1'b1;
				end
			end
		end
	end

	assign quot_o = quo_q;

endmodule : ramp_fraction_div
`default_nettype wire

//--- test/host_motion_model.sv
// Host motion controller model driving status flags and the gain select
`timescale 1ns/100ps
`default_nettype none
module host_motion_model
	import gain_switch_pkg::*;
(
	// Clock
	input  wire logic                         sys_clk_i,
	// Status and select toward the block
	output var gain_switch_pkg::motion_status_t motion_o
);
	initial motion_o = '0;

	// Gap models a slow host; flags change only right after an edge
	task automatic apply(input logic [7:0] bits, input int gap);
		repeat (gap) @(posedge sys_clk_i);
		@(posedge sys_clk_i);
		motion_o <= motion_status_t'(bits);
	endtask : apply
endmodule : host_motion_model
`default_nettype wire

//--- test/servo_gain_set_switcher_tb.sv
// Self-checking bench for the servo gain set switcher
`timescale 1ns/100ps
`default_nettype none
module servo_gain_set_switcher_tb;
	import gain_switch_pkg::*;
	// Short ms tick keeps the run brief; still above the divider latency
	localparam int TICKS = 32;
	logic           sys_clk_i  = 1'b0;
	logic           rst_i      = 1'b1;
	avl_req_t       avl_req_q  = '0;
	logic [31:0]    rdata;
	logic           waitreq;
	motion_status_t motion;
	gain_vec_t      gains;
	logic           active_set;
	logic           ramp_busy;
	int             err_total  = 0;
	int             num_checks = 0;
	int             cycles     = 0;

	always #50 sys_clk_i = ~sys_clk_i;

	servo_gain_set_switcher #(.TICK_CYCLES_P(TICKS)) dut (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .avl_req_i(avl_req_q),
		.avl_readdata_o(rdata), .avl_waitrequest_o(waitreq), .motion_i(motion),
		.gains_o(gains), .active_set_o(active_set), .ramp_busy_o(ramp_busy));
	host_motion_model host (.sys_clk_i(sys_clk_i), .motion_o(motion));

	task automatic give_verdict();
		$display("checks=%0d errors=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : give_verdict

	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 6000) begin
			err_total++;
			give_verdict();
		end
	end

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_word

	task automatic cmp_gains(input gain_vec_t got, input gain_vec_t exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_gains

	// Holds the request until waitrequest is sampled low, then releases it
	task automatic bus(input logic is_wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n = 0;
		@(posedge sys_clk_i);
		avl_req_q <= '{address: a, read: !is_wr, write: is_wr, writedata: d, byteenable: 4'hF};
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (waitreq !== 1'b0 && n < 20);
		cmp_word({31'h0, waitreq}, 32'h0);
		q = rdata;
		avl_req_q <= '0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		cmp_word(q, exp);
	endtask : rd_chk

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask : idle

	function automatic logic [15:0] set2(input int i);
		return 16'h2000 + 16'(i * 256);
	endfunction : set2

	// Follow lanes take their own source; main lanes take the other
	function automatic gain_vec_t want(input logic main_b, input logic fol_b);
		gain_vec_t g;
		for (int i = 0; i < NUM_LANES; i++)
			g[i] = ((i == LANE_FOLLOW_GAIN || i == LANE_FOLLOW_COMP) ? fol_b : main_b) ?
				set2(i) : GAIN_RESET[i];
		return g;
	endfunction : want

	task automatic t_reset();
		cmp_gains(gains, GAIN_RESET);
		cmp_word({31'h0, active_set}, 32'h0);
		rd_chk(OFS_CONFIG, 32'h0);
		for (int i = 0; i < 4; i++) rd_chk(OFS_WAIT_UP + 8'(4 * i), 32'h0);
		for (int i = 0; i < NUM_LANES; i++) rd_chk(OFS_GAIN_B + 8'(4 * i), {16'h0, GAIN_RESET[i]});
	endtask : t_reset

	task automatic t_regs();
		wr(OFS_WAIT_UP, 32'hFFFF);
		rd_chk(OFS_WAIT_UP, 32'hFFFF);
		wr(OFS_WAIT_UP, 32'h0);
		rd_chk(8'h1C, 32'h0);
		wr(OFS_STATUS, 32'hFFFFFFFF);
		rd_chk(OFS_STATUS, 32'h0);
		for (int i = 0; i < NUM_LANES; i++) wr(OFS_GAIN_B + 8'(4 * i), {16'h0, set2(i)});
		rd_chk(OFS_GAIN_B + 8'h08, {16'h0, set2(2)});
	endtask : t_regs

	task automatic t_manual();
		wr(OFS_CONFIG, 32'h0);
		host.apply(8'h05, 0);
		idle(4);
		cmp_gains(gains, want(1'b1, 1'b0));
		cmp_word({31'h0, active_set}, 32'h1);
		host.apply(8'h03, 2);
		idle(4);
		cmp_gains(gains, want(1'b1, 1'b1));
		rd_chk(OFS_STATUS, 32'h25);
		host.apply(8'h02, 0);
		idle(4);
		cmp_gains(gains, want(1'b0, 1'b0));
	endtask : t_manual

	task automatic t_codes();
		logic [7:0] on_bits [6] = '{8'hC0, 8'h80, 8'hA0, 8'h80, 8'h90, 8'h88};
		logic [7:0] off_bits [6] = '{8'h80, 8'hC0, 8'h80, 8'hA0, 8'h80, 8'h80};
		for (int c = 0; c < 6; c++) begin
			host.apply(off_bits[c], 0);
			wr(OFS_CONFIG, {24'h0, 4'(c), METHOD_AUTO});
			idle(8);
			cmp_word({31'h0, active_set}, 32'h0);
			host.apply(on_bits[c], 1);
			idle(8);
			cmp_word({31'h0, active_set}, 32'h1);
			host.apply(on_bits[c] & 8'h7F, 0);
			idle(8);
			cmp_word({31'h0, active_set}, {31'h0, 1'(c % 2)});
		end
	endtask : t_codes

	task automatic t_auto();
		int          n = 0;
		logic [15:0] prev;
		logic        mid = 1'b0;
		logic        ok = 1'b1;
		wr(OFS_WAIT_UP, 32'h2);
		wr(OFS_RAMP_UP, 32'h4);
		wr(OFS_LOOP_CFG, {30'h0, STRUCT_IP});
		wr(OFS_CONFIG, {24'h0, COND_DONE_ON, METHOD_AUTO});
		host.apply(8'h80, 0);
		idle(8);
		cmp_gains(gains, want(1'b0, 1'b0));
		host.apply(8'hC0, 3);
		while (ramp_busy !== 1'b1 && n < 8 * TICKS) begin
			idle(1);
			n++;
		end
		cmp_word({31'h0, n > TICKS && n <= 3 * TICKS + 4}, 32'h1);
		n = 0;
		prev = gains[2];
		while (ramp_busy === 1'b1 && n < 8 * TICKS) begin
			idle(1);
			n++;
			if (gains[2] > 16'h0190 && gains[2] < 16'h2200) mid = 1'b1;
			if (gains[2] < prev || gains[4] !== GAIN_RESET[4]) ok = 1'b0;
			prev = gains[2];
		end
		cmp_word({31'h0, mid & ok}, 32'h1);
		cmp_word({31'h0, n > 2 * TICKS && n <= 5 * TICKS + 4}, 32'h1);
		idle(2);
		cmp_gains(gains, want(1'b1, 1'b0));
	endtask : t_auto

	task automatic t_revert();
		wr(OFS_WAIT_DOWN, 32'h3);
		wr(OFS_RAMP_DOWN, 32'h0);
		host.apply(8'h80, 0);
		idle(TICKS);
		rd_chk(OFS_STATUS, 32'h61);
		host.apply(8'hC0, 0);
		idle(4 * TICKS);
		rd_chk(OFS_STATUS, 32'h21);
		cmp_gains(gains, want(1'b1, 1'b0));
		host.apply(8'h80, 0);
		idle(TICKS);
		cmp_gains(gains, want(1'b1, 1'b0));
		idle(5 * TICKS);
		cmp_gains(gains, want(1'b0, 1'b0));
		cmp_word({31'h0, active_set}, 32'h0);
		// Unsupported loop structure: condition true must not start a switch
		wr(OFS_LOOP_CFG, 32'h2);
		host.apply(8'hC0, 0);
		idle(3 * TICKS);
		cmp_word({31'h0, active_set}, 32'h0);
		cmp_word({31'h0, ramp_busy}, 32'h0);
	endtask : t_revert

	initial begin
		idle(10);
		rst_i <= 1'b0;
		idle(1);
		t_reset();
		t_regs();
		t_manual();
		t_codes();
		t_auto();
		t_revert();
		give_verdict();
	end
endmodule : servo_gain_set_switcher_tb
`default_nettype wire
